/* cpuif_ctrl_regs.sv */
/*
  cpu interface control and system register enable registers, plus the
  virtual group 0 active priorities register.
  assumes: one request per cycle from the core; answer is combinational in
  the same cycle; physical active-priority register 0 lives elsewhere.
*/
// Summary of operation
// - security disable unsupported bit reads one, writes ignored.
// - affinity level 3 valid bit reads one, writes ignored.
// - system error interrupt support bit reads zero.
// - identifier width field reads zero, meaning 16-bit identifiers.
// - priority width field reads four: five bits, 32 levels.
// - active priority registers one to three of either group are undefined.
// - priority mask hint enable gates use of the mask as hint.
// - routing modifier bit reads zero, writes ignored.
// - three writable eoi mode bits choose drop-only or drop and deactivate.
// - two common binary point bits select shared preemption setting.
// - irq bypass disable bit shared by all three enable registers.
// - fiq bypass disable bit shared by all three enable registers.
// - system register interface enable reads one everywhere, writes ignored.
// - hyp enable register lower access bit reads one, writes ignored.
// - top enable register lower access bit reads one, writes ignored.
// - virtual group 0 active priorities reset zero, bit n is priority 8n.
// - for non-secure el1 accesses, hypervisor configuration decides physical or virtual register view.
`timescale 1ns/1ps
`default_nettype none
module cpuif_ctrl_regs
  import cpuif_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire sysreg_req_s req_i,
  input wire logic el1_access_i,
  input wire logic ns_access_i,
  input wire logic hcr_fiq_route_i,
  input wire logic hcr_irq_route_i,
  output sysreg_rsp_s rsp_o,
  output logic prio_mask_hint_enable_o,
  output logic eoi_mode_nonsecure_low_o,
  output logic eoi_mode_secure_low_o,
  output logic eoi_mode_top_o,
  output logic common_bp_nonsecure_o,
  output logic common_bp_secure_o,
  output logic irq_bypass_disable_o,
  output logic fiq_bypass_disable_o,
  output logic [31:0] virt_active_prio_g0_o
);

  // ************************************************************
  // routing and decode
  // ************************************************************
  logic use_virtual;
  reg_sel_e sel;

  cpuif_view_route u_route (
    .el1_access_i(el1_access_i),
    .ns_access_i(ns_access_i),
    .hcr_fiq_route_i(hcr_fiq_route_i),
    .hcr_irq_route_i(hcr_irq_route_i),
    .use_virtual_o(use_virtual)
  );

  cpuif_decode u_decode (
    .enc_i(req_i.enc),
    .use_virtual_i(use_virtual),
    .sel_o(sel)
  );

  // ************************************************************
  // storage
  // ************************************************************
  // writable control bits: prio_mask_hint_enable, eoi ns/s/top, cbp ns/s
  logic [5:0] ctl_reg;
  logic [5:0] ctl_next;
  // single copy of dib/dfb: every enable register view aliases it
  logic [1:0] bypass_reg;
  logic [1:0] bypass_next;
  logic [31:0] vap0_reg;
  logic [31:0] vap0_next;
  logic wr;

  always_comb
  begin
    wr = req_i.valid && req_i.write;
    ctl_next = ctl_reg;
    bypass_next = bypass_reg;
    vap0_next = vap0_reg;
    if (wr)
    begin
      case (sel)
        SEL_CTRL_TOP:
        begin
          // fixed fields and reserved bits are simply not stored
          ctl_next = {req_i.wdata[CTL_PRIO_MASK_HINT_ENABLE_POS],
                      req_i.wdata[CTL_EOI_NS_POS],
                      req_i.wdata[CTL_EOI_S_POS],
                      req_i.wdata[CTL_EOI_TOP_POS],
                      req_i.wdata[CTL_CBP_NS_POS],
                      req_i.wdata[CTL_CBP_S_POS]};
        end
        SEL_SRE_LOW, SEL_SRE_HYP, SEL_SRE_TOP:
        begin
          bypass_next = {req_i.wdata[SRE_DIB_POS],
                         req_i.wdata[SRE_DFB_POS]};
        end
        SEL_VAP0:
        begin
          vap0_next = req_i.wdata;
        end
        default:
        begin
          ctl_next = ctl_reg;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctl_reg <= CTL_RW_RESET;
      bypass_reg <= BYPASS_RESET;
      vap0_reg <= VAP0_RESET;
    end
    else
    begin
      ctl_reg <= ctl_next;
      bypass_reg <= bypass_next;
      vap0_reg <= vap0_next;
    end
  end

  // ************************************************************
  // read views
  // ************************************************************
  function automatic logic [31:0] sre_view(input logic lower_en);
    logic [31:0] v;
    v = 32'h00000000;
    v[SRE_LOWER_EN_POS] = lower_en;
    v[SRE_DIB_POS] = bypass_reg[1];
    v[SRE_DFB_POS] = bypass_reg[0];
    v[SRE_IFACE_POS] = 1'b1;
    sre_view = v;
  endfunction

  logic [31:0] ctl_view;

  always_comb
  begin
    ctl_view = 32'h00000000;
    ctl_view[CTL_SEC_DIS_UNSUP_POS] = 1'b1;
    ctl_view[CTL_AFF3_VALID_POS] = 1'b1;
    ctl_view[CTL_SEI_SUPPORT_POS] = 1'b0;
    ctl_view[CTL_ID_WIDTH_LSB +: 3] = ID_WIDTH_VAL;
    ctl_view[CTL_PRIO_WIDTH_LSB +: 3] = PRIO_WIDTH_VAL;
    ctl_view[CTL_PRIO_MASK_HINT_ENABLE_POS] = ctl_reg[5];
    ctl_view[CTL_RM_POS] = 1'b0;
    ctl_view[CTL_EOI_NS_POS] = ctl_reg[4];
    ctl_view[CTL_EOI_S_POS] = ctl_reg[3];
    ctl_view[CTL_EOI_TOP_POS] = ctl_reg[2];
    ctl_view[CTL_CBP_NS_POS] = ctl_reg[1];
    ctl_view[CTL_CBP_S_POS] = ctl_reg[0];
  end

  always_comb
  begin
    rsp_o.valid = req_i.valid;
    rsp_o.undef = 1'b0;
    rsp_o.rdata = 32'h00000000;
    case (sel)
      SEL_CTRL_TOP:
        rsp_o.rdata = ctl_view;
      // the low register has no lower-access bit of its own
      SEL_SRE_LOW:
        rsp_o.rdata = sre_view(1'b0);
      SEL_SRE_HYP, SEL_SRE_TOP:
        rsp_o.rdata = sre_view(1'b1);
      SEL_VAP0:
        rsp_o.rdata = vap0_reg;
      SEL_UNDEF:
        rsp_o.undef = req_i.valid;
      default:
        rsp_o.rdata = 32'h00000000;
    endcase
  end

  // ************************************************************
  // control outputs to the rest of the interface
  // ************************************************************
  // the hint enable bit leaves the block ungated; distributor side must not
  // read the mask while it is clear
  always_comb
  begin
    prio_mask_hint_enable_o = ctl_reg[5];
    eoi_mode_nonsecure_low_o = ctl_reg[4];
    eoi_mode_secure_low_o = ctl_reg[3];
    eoi_mode_top_o = ctl_reg[2];
    common_bp_nonsecure_o = ctl_reg[1];
    common_bp_secure_o = ctl_reg[0];
    irq_bypass_disable_o = bypass_reg[1];
    fiq_bypass_disable_o = bypass_reg[0];
    virt_active_prio_g0_o = vap0_reg;
  end

endmodule
`default_nettype wire

/* cpuif_regs_pkg.sv */
/*
  package for the cpu interface control and enable register block:
  system register encodings, field positions, fixed values, reset values,
  access carrier structs.
  assumes: the core decodes system register instructions into the
  op0/op1/crn/crm/op2 tuple carried by sysreg_req_s.
*/
package cpuif_regs_pkg;

  // ************************************************************
  // system register encodings
  // ************************************************************
  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_enc_s;

  localparam sysreg_enc_s ENC_CTRL_TOP = '{2'h3, 3'h6, 4'hc, 4'hc, 3'h4};
  localparam sysreg_enc_s ENC_SRE_LOW = '{2'h3, 3'h0, 4'hc, 4'hc, 3'h5};
  localparam sysreg_enc_s ENC_SRE_HYP = '{2'h3, 3'h4, 4'hc, 4'h9, 3'h5};
  localparam sysreg_enc_s ENC_SRE_TOP = '{2'h3, 3'h6, 4'hc, 4'hc, 3'h5};
  // group 0 active priorities n: crm 8, op2 4+n
  localparam sysreg_enc_s ENC_AP0R0 = '{2'h3, 3'h0, 4'hc, 4'h8, 3'h4};
  // group 1 active priorities n: crm 9, op2 0+n
  localparam sysreg_enc_s ENC_AP1R0 = '{2'h3, 3'h0, 4'hc, 4'h9, 3'h0};
  localparam logic [2:0] AP_LAST_IDX = 3'h3;

  // ************************************************************
  // control register field positions and fixed values
  // ************************************************************
  localparam int CTL_SEC_DIS_UNSUP_POS = 17;
  localparam int CTL_AFF3_VALID_POS = 15;
  localparam int CTL_SEI_SUPPORT_POS = 14;
  localparam int CTL_ID_WIDTH_LSB = 11;
  localparam int CTL_PRIO_WIDTH_LSB = 8;
  localparam int CTL_PRIO_MASK_HINT_ENABLE_POS = 6;
  localparam int CTL_RM_POS = 5;
  localparam int CTL_EOI_NS_POS = 4;
  localparam int CTL_EOI_S_POS = 3;
  localparam int CTL_EOI_TOP_POS = 2;
  localparam int CTL_CBP_NS_POS = 1;
  localparam int CTL_CBP_S_POS = 0;
  localparam logic [2:0] ID_WIDTH_VAL = 3'h0;
  localparam logic [2:0] PRIO_WIDTH_VAL = 3'h4;

  // ************************************************************
  // enable register field positions
  // ************************************************************
  localparam int SRE_LOWER_EN_POS = 3;
  localparam int SRE_DIB_POS = 2;
  localparam int SRE_DFB_POS = 1;
  localparam int SRE_IFACE_POS = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [5:0] CTL_RW_RESET = 6'h00;
  localparam logic [1:0] BYPASS_RESET = 2'h0;
  localparam logic [31:0] VAP0_RESET = 32'h00000000;

  // ************************************************************
  // access carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    sysreg_enc_s enc;
    logic [31:0] wdata;
  } sysreg_req_s;

  typedef struct packed {
    logic valid;
    logic undef;
    logic [31:0] rdata;
  } sysreg_rsp_s;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL_TOP,
    SEL_SRE_LOW,
    SEL_SRE_HYP,
    SEL_SRE_TOP,
    SEL_VAP0,
    SEL_UNDEF
  } reg_sel_e;

endpackage

/* cpuif_view_route.sv */
/*
  view router: decides whether an access goes to the physical register
  or to its virtual counterpart.
  assumes: route bits come from the hypervisor_config register, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cpuif_view_route
  import cpuif_regs_pkg::*;
(
  input wire logic el1_access_i,
  input wire logic ns_access_i,
  input wire logic hcr_fiq_route_i,
  input wire logic hcr_irq_route_i,
  output logic use_virtual_o
);
  // ************************************************************
  // routing
  // ************************************************************
  // only non-secure el1 accesses are redirected; higher levels keep the
  // physical view whatever the hypervisor asks
  always_comb
  begin
    use_virtual_o = el1_access_i && ns_access_i &&
                    (hcr_fiq_route_i || hcr_irq_route_i);
  end
endmodule
`default_nettype wire

/* cpuif_decode.sv */
/*
  system register decoder for the control/enable block.
  assumes: request is a single-cycle strobe from the core pipeline.
*/
`timescale 1ns/1ps
`default_nettype none
module cpuif_decode
  import cpuif_regs_pkg::*;
(
  input wire sysreg_enc_s enc_i,
  input wire logic use_virtual_i,
  output reg_sel_e sel_o
);
  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic is_ap(input sysreg_enc_s e,
                                 input sysreg_enc_s base);
    logic [2:0] idx;
    idx = e.op2 - base.op2;
    // register zero itself is defined: only indices one to three refuse
    is_ap = e.op0 == base.op0 && e.op1 == base.op1 && e.crn == base.crn &&
            e.crm == base.crm && e.op2 >= base.op2 && idx != 3'h0 &&
            idx <= AP_LAST_IDX;
  endfunction

  always_comb
  begin
    sel_o = SEL_NONE;
    if (enc_i == ENC_CTRL_TOP)
      sel_o = SEL_CTRL_TOP;
    else if (enc_i == ENC_SRE_LOW)
      sel_o = SEL_SRE_LOW;
    else if (enc_i == ENC_SRE_HYP)
      sel_o = SEL_SRE_HYP;
    else if (enc_i == ENC_SRE_TOP)
      sel_o = SEL_SRE_TOP;
    else if (enc_i == ENC_AP0R0)
      sel_o = use_virtual_i ? SEL_VAP0 : SEL_NONE;
    else if (is_ap(enc_i, ENC_AP0R0) || is_ap(enc_i, ENC_AP1R0))
      sel_o = SEL_UNDEF;
  end
endmodule
`default_nettype wire

/* core_model.sv */
/*
  core side model: issues one system register access at a time.
  assumes: shares sys_clk_i with the register block, answer is same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model
  import cpuif_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire sysreg_rsp_s rsp_i,
  output sysreg_req_s req_o
);
  initial req_o = '0;

  // ****************************************
  // access task, called just after a rising edge
  // ****************************************
  task automatic acc(input logic w, input sysreg_enc_s e,
                     input logic [31:0] d, output sysreg_rsp_s r);
    req_o <= '{1'b1, w, e, d};
    @(posedge sys_clk_i);
    r = rsp_i;
    // released fields carry the inverse so stale values never match
    req_o <= '{1'b0, 1'b0, ~e, ~d};
    @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

/* ctrl_regs_chk_assertions.sv */
/*
  concurrent checks on the control and enable register block ports.
  assumes: single clock domain, bound onto cpuif_ctrl_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module ctrl_regs_chk
  import cpuif_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire sysreg_req_s req_i,
  input wire logic el1_access_i,
  input wire logic ns_access_i,
  input wire logic hcr_fiq_route_i,
  input wire logic hcr_irq_route_i,
  input wire sysreg_rsp_s rsp_o,
  input wire logic prio_mask_hint_enable_o,
  input wire logic eoi_mode_nonsecure_low_o,
  input wire logic eoi_mode_secure_low_o,
  input wire logic eoi_mode_top_o,
  input wire logic common_bp_nonsecure_o,
  input wire logic common_bp_secure_o,
  input wire logic irq_bypass_disable_o,
  input wire logic fiq_bypass_disable_o,
  input wire logic [31:0] virt_active_prio_g0_o
);
  logic rd, wr, vw, ap, sys_reg_iface_enable;
  logic [1:0] byp;
  logic [5:0] ctl;
  sysreg_enc_s e;
  assign e = req_i.enc;
  assign rd = req_i.valid & ~req_i.write;
  assign wr = req_i.valid & req_i.write;
  assign vw = el1_access_i & ns_access_i & (hcr_fiq_route_i | hcr_irq_route_i);
  assign ap = {e.op0, e.op1, e.crn} == 9'h18c && ((e.crm == 4'h8 &&
    e.op2 > 3'h4) || (e.crm == 4'h9 && e.op2 != 3'h0 && e.op2 < 3'h4));
  assign sys_reg_iface_enable = e == ENC_SRE_LOW || e == ENC_SRE_HYP || e == ENC_SRE_TOP;
  assign byp = {irq_bypass_disable_o, fiq_bypass_disable_o};
  assign ctl = {prio_mask_hint_enable_o, eoi_mode_nonsecure_low_o,
    eoi_mode_secure_low_o, eoi_mode_top_o, common_bp_nonsecure_o,
    common_bp_secure_o};

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ****************************************
  // checks
  // ****************************************
  chk_ctrl_fixed: assert property (
    rd && e == ENC_CTRL_TOP |->
    (rsp_o.rdata & 32'hffffffa0) == 32'h00028400)
    else $error("control fixed fields wrong");
  chk_ctrl_view: assert property (
    rd && e == ENC_CTRL_TOP |-> {rsp_o.rdata[6], rsp_o.rdata[4:0]} == ctl)
    else $error("control read differs from outputs");
  chk_ctrl_write: assert property (
    wr && e == ENC_CTRL_TOP |=>
    ctl == {$past(req_i.wdata[6]), $past(req_i.wdata[4:0])})
    else $error("control write not stored");
  chk_bypass_alias: assert property (
    wr && sys_reg_iface_enable |=> byp == $past(req_i.wdata[2:1]))
    else $error("bypass bits not shared");
  chk_sre_upper: assert property (
    rd && (e == ENC_SRE_HYP || e == ENC_SRE_TOP) |->
    rsp_o.rdata == {28'h0, 1'b1, byp, 1'b1})
    else $error("upper enable read wrong");
  chk_sre_low: assert property (
    rd && e == ENC_SRE_LOW |-> rsp_o.rdata == {29'h0, byp, 1'b1})
    else $error("low enable read wrong");
  chk_ap_undef: assert property (
    req_i.valid |-> rsp_o.undef == ap)
    else $error("undefined answer wrong");
  chk_rsp_valid: assert property (
    rsp_o.valid == req_i.valid)
    else $error("answer valid differs from request");
  chk_vap_write: assert property (
    wr && vw && e == ENC_AP0R0 |=> virt_active_prio_g0_o == $past(req_i.wdata))
    else $error("virtual priorities not stored");
  chk_vap_hold: assert property (
    !(wr && vw && e == ENC_AP0R0) |=> $stable(virt_active_prio_g0_o))
    else $error("virtual priorities changed");
endmodule

bind cpuif_ctrl_regs ctrl_regs_chk u_chk (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .req_i(req_i), .el1_access_i(el1_access_i),
  .ns_access_i(ns_access_i), .hcr_fiq_route_i(hcr_fiq_route_i),
  .hcr_irq_route_i(hcr_irq_route_i), .rsp_o(rsp_o),
  .prio_mask_hint_enable_o(prio_mask_hint_enable_o),
  .eoi_mode_nonsecure_low_o(eoi_mode_nonsecure_low_o),
  .eoi_mode_secure_low_o(eoi_mode_secure_low_o),
  .eoi_mode_top_o(eoi_mode_top_o),
  .common_bp_nonsecure_o(common_bp_nonsecure_o),
  .common_bp_secure_o(common_bp_secure_o),
  .irq_bypass_disable_o(irq_bypass_disable_o),
  .fiq_bypass_disable_o(fiq_bypass_disable_o),
  .virt_active_prio_g0_o(virt_active_prio_g0_o));
`default_nettype wire

/* cpuif_ctrl_regs_tb.sv */
/*
  self-checking bench for the control and enable register block.
  assumes: core_model issues accesses, checker is bound to the block.
*/
`timescale 1ns/1ps
`default_nettype none
module cpuif_ctrl_regs_tb
  import cpuif_regs_pkg::*;
  ;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic el1 = 1'b0, ns = 1'b0, fr = 1'b0, ir = 1'b0;
  sysreg_req_s req;
  sysreg_rsp_s rsp, r;
  wire [5:0] ctl;
  wire [1:0] byp;
  wire [31:0] vap;
  sysreg_enc_s e;
  sysreg_enc_s sys_reg_iface_enable [3];
  logic [31:0] d;
  int n_fail = 0;
  int samples_checked = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  core_model core (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));
  cpuif_ctrl_regs dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req),
    .el1_access_i(el1), .ns_access_i(ns), .hcr_fiq_route_i(fr),
    .hcr_irq_route_i(ir), .rsp_o(rsp),
    .prio_mask_hint_enable_o(ctl[5]), .eoi_mode_nonsecure_low_o(ctl[4]),
    .eoi_mode_secure_low_o(ctl[3]), .eoi_mode_top_o(ctl[2]),
    .common_bp_nonsecure_o(ctl[1]), .common_bp_secure_o(ctl[0]),
    .irq_bypass_disable_o(byp[1]), .fiq_bypass_disable_o(byp[0]),
    .virt_active_prio_g0_o(vap));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic rd(input sysreg_enc_s a, input logic [31:0] x, input string nm);
    core.acc(1'b0, a, 32'h0, r);
    chk(nm, r.rdata, x);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_reg_iface_enable = '{ENC_SRE_LOW, ENC_SRE_HYP, ENC_SRE_TOP};
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(ENC_CTRL_TOP, 32'h00028400, "ctrl");
    rd(ENC_SRE_LOW, 32'h1, "sre low");
    rd(ENC_SRE_HYP, 32'h9, "sre hyp");
    rd(ENC_SRE_TOP, 32'h9, "sre top");
    core.acc(1'b1, ENC_CTRL_TOP, 32'hffffffff, r);
    chk("ctl out", {26'h0, ctl}, 32'h3f);
    rd(ENC_CTRL_TOP, 32'h0002845f, "ctrl ones");
    core.acc(1'b1, ENC_CTRL_TOP, 32'h0000000a, r);
    rd(ENC_CTRL_TOP, 32'h0002840a, "ctrl mix");
    $display("control test done");
    // bits 3 and up are written as ones and interface enable bit 0 as zero to prove they are ignored
    for (int i = 0; i < 3; i++)
    begin
      d = 32'h6 - 32'(2 * i);
      core.acc(1'b1, sys_reg_iface_enable[i], 32'hfffffff8 | d, r);
      chk("bypass", {30'h0, byp}, {30'h0, d[2:1]});
      for (int j = 0; j < 3; j++)
        rd(sys_reg_iface_enable[j], {28'h0, j != 0, d[2:1], 1'b1}, "alias");
    end
    $display("enable test done");
    el1 <= 1'b1;
    ns <= 1'b1;
    ir <= 1'b1;
    rd(ENC_AP0R0, 32'h0, "vap reset");
    core.acc(1'b1, ENC_AP0R0, 32'h80000001, r);
    rd(ENC_AP0R0, 32'h80000001, "vap");
    ir <= 1'b0;
    fr <= 1'b1;
    core.acc(1'b1, ENC_AP0R0, 32'h00000002, r);
    chk("vap fiq", vap, 32'h2);
    el1 <= 1'b0;
    core.acc(1'b1, ENC_AP0R0, 32'h0, r);
    chk("vap phys", vap, 32'h2);
    for (int n = 1; n < 4; n++)
    begin
      e = ENC_AP0R0;
      e.op2 = 3'h4 + 3'(n);
      core.acc(1'b0, e, 32'h0, r);
      chk("ap0 undef", {31'h0, r.undef}, 32'h1);
      e = ENC_AP1R0;
      e.op2 = 3'(n);
      core.acc(1'b1, e, 32'hffffffff, r);
      chk("ap1 undef", {31'h0, r.undef}, 32'h1);
    end
    chk("vap kept", vap, 32'h2);
    core.acc(1'b0, ENC_AP1R0, 32'h0, r);
    chk("ap1r0 defined", {31'h0, r.undef}, 32'h0);
    $display("priority test done");
    nrst_i <= 1'b0;
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk("reset outs", {24'h0, ctl, byp} | vap, 32'h0);
    rd(ENC_SRE_TOP, 32'h9, "sre reset");
    $display("reset test done");
    @(posedge sys_clk_i);
    wrap_up;
  end

  // a hang would otherwise run forever
  initial
  begin
    repeat (2000) @(posedge sys_clk_i);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
